// *** rx_frame_status_tx_enqueue_defines.svh ***
`ifndef RX_FRAME_STATUS_TX_ENQUEUE_DEFINES_SVH
`define RX_FRAME_STATUS_TX_ENQUEUE_DEFINES_SVH

// register byte offsets (16-bit registers)
`define OFF_RX_FRAME_HEADER_STATUS     8'h7c
`define OFF_RX_FRAME_HEADER_BYTE_COUNT 8'h7e
`define OFF_TX_QUEUE_COMMAND           8'h80

// header status field positions
`define BIT_FRAME_VALID                15
`define BIT_FRAME_TYPE                 3
`define BIT_OVERSIZE                   2
`define BIT_RUNT                       1
`define BIT_FCS_ERROR                  0

// transmit command field positions
`define BIT_AUTO_ENQUEUE               2
`define BIT_MEMORY_MONITOR             1
`define BIT_MANUAL_ENQUEUE             0

// limits
`define LEN_TYPE_LIMIT                 16'h05dc
`define OVERSIZE_LIMIT                 12'h7d0
`define BYTE_COUNT_WIDTH               12
`define TX_COMMAND_RESET               16'h0000

`endif

// *** rx_frame_status_tx_enqueue_pkg.sv ***
package rx_frame_status_tx_enqueue_pkg;

    // per-frame result handed over by the receive engine
    typedef struct packed {
        logic        runt;
        logic        fcs_error;
        logic [15:0] length_type;
        logic [11:0] byte_count;
    } rx_frame_info_type;

    // register-port request
    typedef struct packed {
        logic        write;
        logic        read;
        logic [7:0]  address;
        logic [15:0] write_data;
    } reg_request_type;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_PENDING = 3'b010,
        ST_SENDING = 3'b100
    } tx_state_type;

endpackage : rx_frame_status_tx_enqueue_pkg

// *** rx_frame_status_tx_enqueue.sv ***
// What this block does
// - frame-type flag is set when the length/type value exceeds 1500 and cleared otherwise.
// - oversize flag is set above 2000 bytes and such frames pass only with pass-bad-frames.
// - oversize is a flag only and never shortens the frame.
// - runt flag is set for collision-damaged or prematurely ended frames.
// - runt frames are queued only with pass-bad-frames, dropped otherwise.
// - header status bit 0 is set when the frame check sequence failed.
// - frames with a check sequence error are queued only with pass-bad-frames.
// - byte count register bits 11-0 give the frame size, bits 15-12 read zero.
// - status and count are captured only for a frame kept while none is held or in a release cycle, and may be read repeatedly.
// - writing auto-enqueue as 1 queues every prepared transmit frame automatically.
// - with the memory monitor set, the memory-available interrupt fires once free memory covers the request.
// - the memory monitor clears itself after the frame finishes transmitting.
// - writing manual-enqueue as 1 queues exactly one prepared frame.
// - manual-enqueue clears itself once that frame has been transmitted.
// - frame-valid is set while any kept frame is counted, including bad frames passed with pass-bad-frames.
`timescale 1ns/1ps
`include "rx_frame_status_tx_enqueue_defines.svh"

module rx_frame_status_tx_enqueue (
    // clock and reset
    input  wire logic                                   clk,
    input  wire logic                                   rst,
    // register port
    input  wire rx_frame_status_tx_enqueue_pkg::reg_request_type req,
    output logic [15:0]                                 read_data,
    // receive engine
    input  wire logic                                   frame_done,
    input  wire rx_frame_status_tx_enqueue_pkg::rx_frame_info_type frame_info,
    input  wire logic                                   pass_bad_frames,
    output logic                                        frame_accept,
    output logic                                        frame_drop,
    input  wire logic                                   frame_release,
    output logic [7:0]                                  received_frame_counter,
    // transmit engine
    input  wire logic [12:0]                            tx_memory_available,
    input  wire logic [12:0]                            next_frame_size_request,
    input  wire logic                                   tx_frame_ready,
    output logic                                        tx_enqueue,
    input  wire logic                                   tx_frame_sent,
    output logic                                        tx_memory_interrupt
);

    logic        frame_type_flag_reg, oversize_flag_reg, runt_flag_reg, fcs_error_flag_reg;
    logic        frame_valid_flag_reg;
    logic [11:0] received_byte_count_reg;
    logic [7:0]  count_reg;
    logic        auto_enqueue_enable_reg, tx_memory_monitor_reg, manual_enqueue_enable_reg;
    logic        monitor_fired_reg;
    rx_frame_status_tx_enqueue_pkg::tx_state_type state_reg, state_next;

    wire oversize_now   = frame_info.byte_count > `OVERSIZE_LIMIT;
    wire frame_is_bad   = frame_info.runt | frame_info.fcs_error | oversize_now;
    wire keep_frame     = frame_done & (~frame_is_bad | pass_bad_frames);
    wire release_one    = frame_release & (count_reg != 8'h00);
    wire wr_command     = req.write & (req.address == `OFF_TX_QUEUE_COMMAND);
    wire memory_ok      = tx_memory_available >= next_frame_size_request;
    wire manual_start   = manual_enqueue_enable_reg & (state_reg == rx_frame_status_tx_enqueue_pkg::ST_IDLE);
    wire auto_start     = auto_enqueue_enable_reg & tx_frame_ready;
    wire [15:0] status_word = {frame_valid_flag_reg, 11'h000, frame_type_flag_reg,
                               oversize_flag_reg, runt_flag_reg, fcs_error_flag_reg};
    wire [15:0] count_word  = {4'h0, received_byte_count_reg};
    wire [15:0] cmd_word    = {13'h0000, auto_enqueue_enable_reg, tx_memory_monitor_reg,
                               manual_enqueue_enable_reg};

    assign frame_accept           = keep_frame;
    assign frame_drop             = frame_done & ~keep_frame;
    assign received_frame_counter = count_reg;
    assign tx_enqueue             = (state_reg == rx_frame_status_tx_enqueue_pkg::ST_PENDING);
    assign read_data = (req.address == `OFF_RX_FRAME_HEADER_STATUS)     ? status_word :
                       (req.address == `OFF_RX_FRAME_HEADER_BYTE_COUNT) ? count_word  :
                       (req.address == `OFF_TX_QUEUE_COMMAND)           ? cmd_word    : 16'h0000;

    // status of the frame at the head stays until the host releases it
    always_ff @(posedge clk) begin
        if (rst) begin
            frame_type_flag_reg     <= 1'b0;
            oversize_flag_reg       <= 1'b0;
            runt_flag_reg           <= 1'b0;
            fcs_error_flag_reg      <= 1'b0;
            received_byte_count_reg <= 12'h000;
            frame_valid_flag_reg    <= 1'b0;
        end else if (keep_frame && (!frame_valid_flag_reg || release_one)) begin
            frame_type_flag_reg     <= frame_info.length_type > `LEN_TYPE_LIMIT;
            oversize_flag_reg       <= oversize_now;
            runt_flag_reg           <= frame_info.runt;
            fcs_error_flag_reg      <= frame_info.fcs_error;
            received_byte_count_reg <= frame_info.byte_count;
            frame_valid_flag_reg    <= 1'b1;
        end else if (release_one && count_reg == 8'h01) begin
            frame_valid_flag_reg    <= 1'b0;
        end
    end

    // counted frames; status captured only for a frame kept while none is held or at a release
    always_ff @(posedge clk) begin
        if (rst)
            count_reg <= 8'h00;
        else
            count_reg <= count_reg + {7'h00, keep_frame & (count_reg != 8'hff)}
                         - {7'h00, release_one};
    end

    // transmit command bits
    always_ff @(posedge clk) begin
        if (rst) begin
            auto_enqueue_enable_reg   <= 1'b0;
            tx_memory_monitor_reg     <= 1'b0;
            manual_enqueue_enable_reg <= 1'b0;
        end else begin
            if (wr_command)
                auto_enqueue_enable_reg <= req.write_data[`BIT_AUTO_ENQUEUE];
            if (wr_command && req.write_data[`BIT_MEMORY_MONITOR])
                tx_memory_monitor_reg <= 1'b1;
            else if (tx_frame_sent)
                tx_memory_monitor_reg <= 1'b0;
            if (wr_command && req.write_data[`BIT_MANUAL_ENQUEUE])
                manual_enqueue_enable_reg <= 1'b1;
            else if (tx_frame_sent && state_reg == rx_frame_status_tx_enqueue_pkg::ST_SENDING)
                manual_enqueue_enable_reg <= 1'b0;
        end
    end

    // one interrupt pulse per monitor arming
    always_ff @(posedge clk) begin
        if (rst) begin
            monitor_fired_reg   <= 1'b0;
            tx_memory_interrupt <= 1'b0;
        end else begin
            tx_memory_interrupt <= tx_memory_monitor_reg & memory_ok & ~monitor_fired_reg;
            if (!tx_memory_monitor_reg)
                monitor_fired_reg <= 1'b0;
            else if (memory_ok)
                monitor_fired_reg <= 1'b1;
        end
    end

    // enqueue sequencer: one frame per manual request, repeated while auto is set
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            rx_frame_status_tx_enqueue_pkg::ST_IDLE:
                if (manual_start || auto_start)
                    state_next = rx_frame_status_tx_enqueue_pkg::ST_PENDING;
            rx_frame_status_tx_enqueue_pkg::ST_PENDING:
                state_next = rx_frame_status_tx_enqueue_pkg::ST_SENDING;
            rx_frame_status_tx_enqueue_pkg::ST_SENDING:
                if (tx_frame_sent)
                    state_next = rx_frame_status_tx_enqueue_pkg::ST_IDLE;
            default:
                state_next = rx_frame_status_tx_enqueue_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst)
            state_reg <= rx_frame_status_tx_enqueue_pkg::ST_IDLE;
        else
            state_reg <= state_next;
    end

    property p_type_flag;
        @(posedge clk) disable iff (rst)
        (keep_frame && !frame_valid_flag_reg) |=>
            frame_type_flag_reg == ($past(frame_info.length_type) > `LEN_TYPE_LIMIT);
    endproperty
    a_type_flag: assert property (p_type_flag) else $error("frame type flag wrong");

    property p_oversize;
        @(posedge clk) disable iff (rst)
        (keep_frame && !frame_valid_flag_reg) |=>
            oversize_flag_reg == ($past(frame_info.byte_count) > `OVERSIZE_LIMIT);
    endproperty
    a_oversize: assert property (p_oversize) else $error("oversize flag wrong");

    property p_no_truncate;
        @(posedge clk) disable iff (rst)
        (keep_frame && !frame_valid_flag_reg) |=>
            received_byte_count_reg == $past(frame_info.byte_count);
    endproperty
    a_no_truncate: assert property (p_no_truncate) else $error("byte count altered");

    property p_bad_drop;
        @(posedge clk) disable iff (rst)
        (frame_done && !pass_bad_frames &&
         (frame_info.runt || frame_info.fcs_error || oversize_now))
            |-> frame_drop && !frame_accept;
    endproperty
    a_bad_drop: assert property (p_bad_drop) else $error("bad frame not dropped");

    property p_fcs_pass;
        @(posedge clk) disable iff (rst)
        (frame_done && pass_bad_frames) |-> frame_accept;
    endproperty
    a_fcs_pass: assert property (p_fcs_pass) else $error("passed frame dropped");

    property p_runt_bit;
        @(posedge clk) disable iff (rst)
        (keep_frame && !frame_valid_flag_reg && frame_info.runt) |=> runt_flag_reg;
    endproperty
    a_runt_bit: assert property (p_runt_bit) else $error("runt flag missing");

    property p_count_reserved;
        @(posedge clk) disable iff (rst)
        (req.address == `OFF_RX_FRAME_HEADER_BYTE_COUNT) |-> read_data[15:12] == 4'h0;
    endproperty
    a_count_reserved: assert property (p_count_reserved) else $error("reserved bits set");

    property p_valid;
        @(posedge clk) disable iff (rst)
        frame_valid_flag_reg |-> count_reg != 8'h00;
    endproperty
    a_valid: assert property (p_valid) else $error("valid with no frame");

    property p_manual_clear;
        @(posedge clk) disable iff (rst)
        (state_reg == rx_frame_status_tx_enqueue_pkg::ST_SENDING && tx_frame_sent && !wr_command)
            |=> !manual_enqueue_enable_reg && !tx_memory_monitor_reg;
    endproperty
    a_manual_clear: assert property (p_manual_clear) else $error("self clear missing");

    property p_enqueue_once;
        @(posedge clk) disable iff (rst)
        tx_enqueue |=> !tx_enqueue;
    endproperty
    a_enqueue_once: assert property (p_enqueue_once) else $error("enqueue repeated");

    property p_monitor_irq;
        @(posedge clk) disable iff (rst)
        (tx_memory_monitor_reg && memory_ok && !monitor_fired_reg) |=> tx_memory_interrupt;
    endproperty
    a_monitor_irq: assert property (p_monitor_irq) else $error("interrupt missing");

endmodule : rx_frame_status_tx_enqueue

// *** host_register_model.sv ***
`timescale 1ns/1ps
`include "rx_frame_status_tx_enqueue_defines.svh"

module host_register_model (
    // clock
    input  wire logic                                       clk,
    // register port
    output rx_frame_status_tx_enqueue_pkg::reg_request_type req,
    input  wire logic [15:0]                                read_data
);
    initial req = '0;

    // request held across the taking edge, released at the next falling edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        req <= '{1'b1, 1'b0, a, d};
        @(negedge clk);
        req <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk);
        req <= '{1'b0, 1'b1, a, 16'h0000};
        #1 d = read_data;
        @(negedge clk);
        req <= '0;
    endtask : rd

    // software waits for a self-clearing bit before reusing it
    task automatic poll_clear(input logic [15:0] m, output logic ok);
        logic [15:0] v;
        ok = 1'b0;
        for (int i = 0; i < 64 && !ok; i++) begin
            rd(`OFF_TX_QUEUE_COMMAND, v);
            ok = (v & m) == 16'h0000;
        end
    endtask : poll_clear
endmodule : host_register_model

// *** rx_frame_status_tx_enqueue_tb.sv ***
`timescale 1ns/1ps
`include "rx_frame_status_tx_enqueue_defines.svh"

module rx_frame_status_tx_enqueue_tb;
    rx_frame_status_tx_enqueue_pkg::reg_request_type   req;
    rx_frame_status_tx_enqueue_pkg::rx_frame_info_type info;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] rdata, v;
    logic        done, pass, accept, drop, rel, ready, enq, sent, intr, ok;
    logic [7:0]  count;
    logic [12:0] avail, need;
    logic [31:0] seed = 32'haa9dad5b;
    int          err_total = 0, check_count = 0, cycles = 0, enq_seen = 0, intr_seen = 0, e0;

    always #2 clk = ~clk;

    rx_frame_status_tx_enqueue dut (.clk(clk), .rst(rst), .req(req), .read_data(rdata),
        .frame_done(done), .frame_info(info), .pass_bad_frames(pass), .frame_accept(accept),
        .frame_drop(drop), .frame_release(rel), .received_frame_counter(count),
        .tx_memory_available(avail), .next_frame_size_request(need), .tx_frame_ready(ready),
        .tx_enqueue(enq), .tx_frame_sent(sent), .tx_memory_interrupt(intr));
    host_register_model host (.clk(clk), .req(req), .read_data(rdata));

    task automatic report_and_stop;
        if (err_total == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (enq === 1'b1) enq_seen <= enq_seen + 1;
        if (intr === 1'b1) intr_seen <= intr_seen + 1;
        if (cycles == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    function automatic logic [15:0] exp_status(input logic [15:0] lt, input logic [11:0] bc,
                                               input logic [1:0] rf);
        return {1'b1, 11'h000, lt > 16'h05dc, bc > 12'h7d0, rf};
    endfunction : exp_status

    // one received frame: accept or drop, status shown, read twice, released
    task automatic frame(input logic [15:0] lt, input logic [11:0] bc, input logic [1:0] rf,
                         input logic pb);
        logic        keep;
        logic [15:0] m;
        keep = pb | ~(rf[1] | rf[0] | (bc > 12'h7d0));
        m = rf[1] ? 16'hfff7 : 16'hffff;
        @(negedge clk);
        info = '{rf[1], rf[0], lt, bc};
        pass = pb;
        done = 1'b1;
        #1 check({15'h0000, accept}, {15'h0000, keep});
        check({15'h0000, drop}, {15'h0000, ~keep});
        @(negedge clk);
        done = 1'b0;
        check({8'h00, count}, {15'h0000, keep});
        repeat (2) begin
            host.rd(`OFF_RX_FRAME_HEADER_STATUS, v);
            if (keep) check(v & m, exp_status(lt, bc, rf) & m);
            else check(v & 16'h8000, 16'h0000);
            host.rd(`OFF_RX_FRAME_HEADER_BYTE_COUNT, v);
            if (keep) check(v, {4'h0, bc});
        end
        @(negedge clk);
        rel = keep;
        @(negedge clk);
        rel = 1'b0;
        check({8'h00, count}, 16'h0000);
    endtask : frame

    task automatic pulse_sent;
        @(negedge clk);
        sent = 1'b1;
        @(negedge clk);
        sent = 1'b0;
    endtask : pulse_sent

    initial begin
        {done, pass, rel, ready, sent, info, avail, need} = '0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        host.rd(`OFF_TX_QUEUE_COMMAND, v);
        check(v, 16'h0000);
        frame(16'h05dc, 12'h7d0, 2'b00, 1'b0);
        frame(16'h05dd, 12'h7d1, 2'b00, 1'b0);
        frame(16'h05dd, 12'h7d1, 2'b00, 1'b1);
        frame(16'h0040, 12'h03c, 2'b10, 1'b0);
        frame(16'h0800, 12'h100, 2'b01, 1'b1);
        for (int i = 0; i < 24; i++) begin
            seed = xs(seed);
            frame(seed[15:0], seed[27:16], seed[29:28], seed[30]);
        end
        // two frames counted before the host releases the first
        @(negedge clk);
        info = '{1'b0, 1'b0, 16'h0800, 12'h040};
        done = 1'b1;
        @(negedge clk);
        info = '{1'b0, 1'b0, 16'h0600, 12'h050};
        @(negedge clk);
        done = 1'b0;
        check({8'h00, count}, 16'h0002);
        host.rd(`OFF_RX_FRAME_HEADER_BYTE_COUNT, v);
        check(v, 16'h0040);
        rel = 1'b1;
        @(negedge clk);
        check({8'h00, count}, 16'h0001);
        @(negedge clk);
        rel = 1'b0;
        check({8'h00, count}, 16'h0000);
        host.rd(`OFF_RX_FRAME_HEADER_STATUS, v);
        check(v & 16'h8000, 16'h0000);
        host.wr(`OFF_RX_FRAME_HEADER_STATUS, 16'hffff);
        host.rd(`OFF_RX_FRAME_HEADER_STATUS, v);
        check(v & 16'h8000, 16'h0000);
        ready = 1'b1;
        e0 = enq_seen;
        host.wr(`OFF_TX_QUEUE_COMMAND, 16'hfff9);
        host.rd(`OFF_TX_QUEUE_COMMAND, v);
        check(v, 16'h0001);
        repeat (6) @(negedge clk);
        pulse_sent();
        host.poll_clear(16'h0001, ok);
        check({15'h0000, ok}, 16'h0001);
        check(16'(enq_seen - e0), 16'h0001);
        avail = 13'h0100;
        need = 13'h0200;
        e0 = intr_seen;
        host.wr(`OFF_TX_QUEUE_COMMAND, 16'h0002);
        repeat (8) @(negedge clk);
        check(16'(intr_seen - e0), 16'h0000);
        avail = 13'h0200;
        repeat (8) @(negedge clk);
        check(16'(intr_seen - e0), 16'h0001);
        pulse_sent();
        host.poll_clear(16'h0002, ok);
        check({15'h0000, ok}, 16'h0001);
        e0 = enq_seen;
        host.wr(`OFF_TX_QUEUE_COMMAND, 16'h0004);
        repeat (4) @(negedge clk);
        check(16'(enq_seen - e0), 16'h0001);
        pulse_sent();
        repeat (4) @(negedge clk);
        check(16'(enq_seen - e0), 16'h0002);
        ready = 1'b0;
        pulse_sent();
        repeat (4) @(negedge clk);
        check(16'(enq_seen - e0), 16'h0002);
        report_and_stop();
    end
endmodule : rx_frame_status_tx_enqueue_tb
